// ---- src/trx_ctrl_regs.v ----
// Control and status register bank of the transceiver
`timescale 1ns/1ps
`include "trx_regs_map.vh"
module trx_ctrl_regs
#(
	parameter [15:0] CHIP_ID_VAL = 16'h0a5a, // Arbitrary value
	parameter [15:0] REV_VAL     = 16'h0001  // Arbitrary value
)
(
	// Clock and reset
	input  wire        mclk,
	input  wire        rst,
	// Serial pins
	input  wire        sen_n,
	input  wire        sck,
	input  wire        sdi,
	output reg         sdo_q,
	output reg         sdo_oe_q,
	// Power-down pin
	input  wire        pdn_pin,
	// Status from radio core
	input  wire [7:0]  rf_strength_level,
	input  wire [7:0]  noise_level,
	input  wire [7:0]  tx_path_level,
	input  wire [7:0]  microphone_level,
	input  wire        tone_a_match,
	input  wire        tone_b_match,
	input  wire        code_normal_match,
	input  wire        code_inverted_match,
	input  wire        phase_detect,
	input  wire [1:0]  phase_shift,
	input  wire        subaudio_match,
	input  wire        vox_match,
	input  wire        squelch_match,
	input  wire        synth_locked,
	input  wire        code_sample,
	input  wire        dtmf_ready,
	// Control to radio core
	output reg         rf_out_en_q,
	output reg  [2:0]  ldo_code_q,
	output reg         xtal_26m_q,
	output reg         half_rate_ref_q,
	output reg         wide_analog_q,
	output reg         wide_dsp_q,
	output reg         tx_on_q,
	output reg         rx_on_q,
	output reg         audio_mute_q,
	output reg         vox_enable_q,
	output reg         auto_squelch_enable_q,
	output reg         tail_elim_q,
	output reg         chip_enable_q,
	output reg         cal_enable_q,
	output reg         tx_converter_reset_q,
	output reg         signal_proc_reset_q,
	output reg  [29:0] rf_freq_q,
	output reg  [5:0]  agc_target_q,
	output reg  [15:0] irq_enable_q,
	output reg  [15:0] filter_bypass_q,
	output reg         pin3_out_q,
	output reg         pin6_out_q
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	reg [1:0] sen_sy_q;
	reg [1:0] sck_sy_q;
	reg [1:0] sdi_sy_q;
	reg [1:0] pdn_sy_q;
	reg       sck_old_q;

	always @(posedge mclk)
	begin
		if (rst)
		begin
			sen_sy_q  <= 2'b11;
			sck_sy_q  <= 2'b00;
			sdi_sy_q  <= 2'b00;
			pdn_sy_q  <= 2'b00;
			sck_old_q <= 1'b0;
		end
		else
		begin
			sen_sy_q  <= {sen_sy_q[0], sen_n};
			sck_sy_q  <= {sck_sy_q[0], sck};
			sdi_sy_q  <= {sdi_sy_q[0], sdi};
			pdn_sy_q  <= {pdn_sy_q[0], pdn_pin};
			sck_old_q <= sck_sy_q[1];
		end
	end

	// ----------------------------------------
	// Serial clock edges
	// ----------------------------------------
	// Only the second stage is read; the first may still be settling
	wire sck_rise = sck_sy_q[1] & ~sck_old_q;
	wire sck_fall = ~sck_sy_q[1] & sck_old_q;

	// ----------------------------------------
	// Serial frame engine
	// ----------------------------------------
	wire        wr_stb;
	wire [6:0]  wr_addr;
	wire [15:0] wr_data;
	reg  [15:0] rdata;
	wire        sdo_w;
	wire        sdo_oe_w;

	trx_serial_port u_port
	(
		.mclk     (mclk),
		.rst      (rst),
		.sen_n_s  (sen_sy_q[1]),
		.sck_rise (sck_rise),
		.sck_fall (sck_fall),
		.sdi_s    (sdi_sy_q[1]),
		.wr_stb_q (wr_stb),
		.addr_q   (wr_addr),
		.wdata_q  (wr_data),
		.rdata    (rdata),
		.sdo_q    (sdo_w),
		.sdo_oe_q (sdo_oe_w)
	);

	// ----------------------------------------
	// Writable registers
	// ----------------------------------------
	reg [15:0] txconv_q;
	reg [15:0] clk_q;
	reg [15:0] regbyp_q;
	reg [15:0] digreg_q;
	reg [15:0] pagain_q;
	reg [15:0] iftune_q;
	reg [15:0] lkdsp_q;
	reg [15:0] freqh_q;
	reg [15:0] freql_q;
	reg [15:0] irqen_q;
	reg [15:0] main_q;
	reg [15:0] agc_q;
	reg [15:0] path_q;
	reg [15:0] txvg_q;
	reg [15:0] audg_q;
	reg [15:0] subtx_q;
	reg [15:0] filt_q;

	// ----------------------------------------
	// Write masks and soft reset
	// ----------------------------------------
	// Unused high bits and reserved enables must read back as zero
	// Shared by the upper frequency word and interrupt-enable writes
	function [15:0] wr_mask;
		input [6:0] a;
		begin
			case (a)
				`TRX_A_FREQH: wr_mask = `TRX_FH_MASK;
				`TRX_A_IRQEN: wr_mask = `TRX_IRQ_MASK;
				default:      wr_mask = 16'hffff;
			endcase
		end
	endfunction

	// Soft reset takes effect on the write itself; bit self-clears after
	wire soft_rst = wr_stb && wr_addr == `TRX_A_MAIN
		&& wr_data[`TRX_M_SRST];

	always @(posedge mclk)
	begin
		if (rst || soft_rst)
		begin
			txconv_q <= `TRX_R_TXCONV;
			clk_q    <= `TRX_R_CLK;
			regbyp_q <= `TRX_R_REGBYP;
			digreg_q <= `TRX_R_DIGREG;
			pagain_q <= `TRX_R_PAGAIN;
			iftune_q <= `TRX_R_IFTUNE;
			lkdsp_q  <= `TRX_R_LKDSP;
			freqh_q  <= `TRX_R_FREQH;
			freql_q  <= `TRX_R_FREQL;
			irqen_q  <= `TRX_R_IRQEN;
			main_q   <= `TRX_R_MAIN;
			agc_q    <= `TRX_R_AGC;
			path_q   <= `TRX_R_PATH;
			txvg_q   <= `TRX_R_TXVG;
			audg_q   <= `TRX_R_AUDG;
			subtx_q  <= `TRX_R_SUBTX;
			filt_q   <= `TRX_R_FILT;
		end
		else if (wr_stb)
		begin
			// Identifier, revision and status offsets fall through
			case (wr_addr)
				`TRX_A_TXCONV: txconv_q <= wr_data;
				`TRX_A_CLK:    clk_q    <= wr_data;
				`TRX_A_REGBYP: regbyp_q <= wr_data;
				`TRX_A_DIGREG: digreg_q <= wr_data;
				`TRX_A_PAGAIN: pagain_q <= wr_data;
				`TRX_A_IFTUNE: iftune_q <= wr_data;
				`TRX_A_LKDSP:  lkdsp_q  <= wr_data;
				`TRX_A_FREQH:  freqh_q  <= wr_data & wr_mask(wr_addr);
				`TRX_A_FREQL:  freql_q  <= wr_data;
				`TRX_A_IRQEN:  irqen_q  <= wr_data & wr_mask(wr_addr);
				`TRX_A_MAIN:   main_q   <= wr_data;
				`TRX_A_AGC:    agc_q    <= wr_data;
				`TRX_A_PATH:   path_q   <= wr_data;
				`TRX_A_TXVG:   txvg_q   <= wr_data;
				`TRX_A_AUDG:   audg_q   <= wr_data;
				`TRX_A_SUBTX:  subtx_q  <= wr_data;
				`TRX_A_FILT:   filt_q   <= wr_data;
				default:       txconv_q <= txconv_q;
			endcase
		end
	end

	// ----------------------------------------
	// Status words
	// ----------------------------------------
	// Status inputs are mclk levels and need no resync
	wire [15:0] flags_w = {6'h00, tone_a_match, tone_b_match,
		code_normal_match, code_inverted_match, phase_detect,
		phase_shift, subaudio_match, vox_match, squelch_match};

	// Offsets with no register read as zero
	always @*
	begin
		case (wr_addr)
			`TRX_A_ID:     rdata = CHIP_ID_VAL;
			`TRX_A_REV:    rdata = REV_VAL;
			`TRX_A_TXCONV: rdata = txconv_q;
			`TRX_A_CLK:    rdata = clk_q;
			`TRX_A_REGBYP: rdata = regbyp_q;
			`TRX_A_DIGREG: rdata = digreg_q;
			`TRX_A_PAGAIN: rdata = pagain_q;
			`TRX_A_LOCK:   rdata = {synth_locked, 15'h0000};
			`TRX_A_IFTUNE: rdata = iftune_q;
			`TRX_A_TXLVL:  rdata = {tx_path_level, microphone_level};
			`TRX_A_RXLVL:  rdata = {rf_strength_level, noise_level};
			`TRX_A_FLAGS:  rdata = flags_w;
			`TRX_A_LKDSP:  rdata = lkdsp_q;
			`TRX_A_FREQH:  rdata = freqh_q;
			`TRX_A_FREQL:  rdata = freql_q;
			`TRX_A_IRQEN:  rdata = irqen_q;
			`TRX_A_MAIN:   rdata = main_q;
			`TRX_A_AGC:    rdata = agc_q;
			`TRX_A_PATH:   rdata = path_q;
			`TRX_A_TXVG:   rdata = txvg_q;
			`TRX_A_AUDG:   rdata = audg_q;
			`TRX_A_SUBTX:  rdata = subtx_q;
			`TRX_A_FILT:   rdata = filt_q;
			default:       rdata = 16'h0000;
		endcase
	end

	// ----------------------------------------
	// Serial data out pins
	// ----------------------------------------
	// Retimed here so the pins come straight from top-level flops
	// Released pin has its data bit held low with sdo_oe_q low, so it is not driven
	always @(posedge mclk)
	begin
		if (rst)
		begin
			sdo_q    <= 1'b0;
			sdo_oe_q <= 1'b0;
		end
		else
		begin
			sdo_q    <= sdo_w;
			sdo_oe_q <= sdo_oe_w;
		end
	end

	// ----------------------------------------
	// Registered control outputs
	// ----------------------------------------
	always @(posedge mclk)
	begin
		if (rst)
		begin
			rf_out_en_q           <= 1'b0;
			ldo_code_q            <= 3'h0;
			xtal_26m_q            <= 1'b0;
			half_rate_ref_q       <= 1'b0;
			wide_analog_q         <= 1'b0;
			wide_dsp_q            <= 1'b0;
			tx_on_q               <= 1'b0;
			rx_on_q               <= 1'b0;
			audio_mute_q          <= 1'b0;
			vox_enable_q          <= 1'b0;
			auto_squelch_enable_q <= 1'b0;
			tail_elim_q           <= 1'b0;
			chip_enable_q         <= 1'b0;
			cal_enable_q          <= 1'b0;
			tx_converter_reset_q  <= 1'b0;
			signal_proc_reset_q   <= 1'b0;
			rf_freq_q             <= 30'h0000_0000;
			agc_target_q          <= 6'h00;
			irq_enable_q          <= 16'h0000;
			filter_bypass_q       <= 16'h0000;
		end
		else
		begin
			// Lost lock kills RF unless detection is disabled
			rf_out_en_q <= (tx_on_q | rx_on_q)
				& (synth_locked | lkdsp_q[`TRX_LK_DIS]);
			// Bypassed regulators leave the code at zero
			ldo_code_q <= regbyp_q[`TRX_LDO_BYP] ? 3'h0
				: digreg_q[`TRX_LDO_HI:`TRX_LDO_LO];
			xtal_26m_q      <= main_q[`TRX_M_XTAL];
			half_rate_ref_q <= clk_q[0];
			wide_analog_q   <= main_q[`TRX_M_FBAND];
			wide_dsp_q      <= main_q[`TRX_M_DBAND];
			tx_on_q         <= main_q[`TRX_M_TXON];
			rx_on_q         <= main_q[`TRX_M_RXON];
			audio_mute_q    <= main_q[`TRX_M_MUTE] & main_q[`TRX_M_RXON];
			vox_enable_q    <= main_q[`TRX_M_VOX];
			auto_squelch_enable_q <= main_q[`TRX_M_SQ];
			tail_elim_q     <= main_q[`TRX_M_TAIL];
			// Either the pin or the bit enables the chip
			chip_enable_q   <= pdn_sy_q[1] | main_q[`TRX_M_PDN];
			cal_enable_q    <= main_q[`TRX_M_CAL];
			tx_converter_reset_q <= txconv_q[`TRX_TXC_DR]
				& txconv_q[`TRX_TXC_RST];
			signal_proc_reset_q <= lkdsp_q[`TRX_DSP_DR]
				& lkdsp_q[`TRX_DSP_RST];
			rf_freq_q <= {freqh_q[`TRX_FH_BITS-1:0], freql_q};
			agc_target_q <= agc_q[`TRX_AGC_HI:`TRX_AGC_LO];
			irq_enable_q <= irqen_q;
			filter_bypass_q <= filt_q;
		end
	end

	// ----------------------------------------
	// Status routing to pins
	// ----------------------------------------
	// Status inputs share mclk, so one register stage is enough
	always @(posedge mclk)
	begin
		if (rst)
		begin
			pin3_out_q <= 1'b0;
			pin6_out_q <= 1'b0;
		end
		else
		begin
			pin3_out_q <= path_q[`TRX_P_CODE] ? code_sample
				: dtmf_ready;
			pin6_out_q <= path_q[`TRX_P_PIN6]
				? (squelch_match & subaudio_match) : squelch_match;
		end
	end
endmodule

// ---- src/trx_regs_map.vh ----
// Register offsets, field positions, reset values and serial framing constants
// Function
// - Interrupt enables at bits 11,9,8,7,6,2,0; host enables one source.
// - Filter register bits bypass filters; bit 0 picks tone lowpass width.
// - RF strength upper byte, noise lower byte, read-only, 1 dB steps.
// - Tx path level upper byte, microphone lower byte, half-dB steps.
// - Flag register shows tone, code, phase, sub-audio, vox, squelch.
// - Phase shift in flag bits 4:3: none,120,180,240 degrees.
// - Lock-detect disable zero shuts RF on lost lock; one keeps it.
// - Read-only lock flag reads one when locked.
// - Digital regulator code applies only while master bypass is zero.
// - Control bit 14 selects crystal family, one for 26/13 MHz.
// - Clock config bit 0 selects half-rate reference when one.
// - Control bits 13 and 12 select analog and DSP channel width.
// - Bit 6 transmit on, bit 5 receive on, bit 7 mutes receive audio.
// - Bits 4, 3, 11 enable vox, auto squelch, tail elimination.
// - Bit 2 acts as power-down pin enable; bit 1 enables calibration.
// - Writing one to control bit 0 restores all register defaults.
// - Direct bit set lets companion bit hold tx converter or DSP reset.
// - 30-bit frequency: upper 14 bits one register, lower 16 next.
// - Six-bit field sets AGC target power in 2 dB steps.
// - Path bit 15 routes code sample or DTMF ready to pin 3.
// - Pin 6 outputs squelch AND sub-audio when select set, else squelch.
`ifndef TRX_REGS_MAP_VH
`define TRX_REGS_MAP_VH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define TRX_A_ID      7'h00
`define TRX_A_REV     7'h01
`define TRX_A_TXCONV  7'h03
`define TRX_A_CLK     7'h04
`define TRX_A_REGBYP  7'h08
`define TRX_A_DIGREG  7'h09
`define TRX_A_PAGAIN  7'h0a
`define TRX_A_LOCK    7'h0d
`define TRX_A_IFTUNE  7'h15
`define TRX_A_TXLVL   7'h1a
`define TRX_A_RXLVL   7'h1b
`define TRX_A_FLAGS   7'h1c
`define TRX_A_LKDSP   7'h24
`define TRX_A_FREQH   7'h29
`define TRX_A_FREQL   7'h2a
`define TRX_A_IRQEN   7'h2d
`define TRX_A_MAIN    7'h30
`define TRX_A_AGC     7'h32
`define TRX_A_PATH    7'h3a
`define TRX_A_TXVG    7'h41
`define TRX_A_AUDG    7'h44
`define TRX_A_SUBTX   7'h4e
`define TRX_A_FILT    7'h58

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TRX_R_TXCONV  16'h2b51
`define TRX_R_CLK     16'h0fd1
`define TRX_R_REGBYP  16'h02a0
`define TRX_R_DIGREG  16'h03c2
`define TRX_R_PAGAIN  16'h7c20
`define TRX_R_IFTUNE  16'h1100
`define TRX_R_LKDSP   16'h0001
`define TRX_R_FREQH   16'h2486
`define TRX_R_FREQL   16'h3a84
`define TRX_R_IRQEN   16'h0000
`define TRX_R_MAIN    16'h0000
`define TRX_R_AGC     16'h7497
`define TRX_R_PATH    16'h40c3
`define TRX_R_TXVG    16'h4006
`define TRX_R_AUDG    16'h00ff
`define TRX_R_SUBTX   16'h20c2
`define TRX_R_FILT    16'h8481

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TRX_IRQ_MASK  16'h0bc5
`define TRX_M_XTAL    14
`define TRX_M_FBAND   13
`define TRX_M_DBAND   12
`define TRX_M_TAIL    11
`define TRX_M_DIRECT  10
`define TRX_M_MUTE    7
`define TRX_M_TXON    6
`define TRX_M_RXON    5
`define TRX_M_VOX     4
`define TRX_M_SQ      3
`define TRX_M_PDN     2
`define TRX_M_CAL     1
`define TRX_M_SRST    0
`define TRX_TXC_DR    12
`define TRX_TXC_RST   11
`define TRX_LK_DIS    15
`define TRX_DSP_DR    7
`define TRX_DSP_RST   6
`define TRX_LDO_BYP   14
`define TRX_LDO_HI    9
`define TRX_LDO_LO    7
`define TRX_AGC_HI    11
`define TRX_AGC_LO    6
`define TRX_P_CODE    15
`define TRX_P_PIN6    11
`define TRX_FH_BITS   14
`define TRX_FH_MASK   16'h3fff

// ----------------------------------------
// Serial frame
// ----------------------------------------
`define TRX_FRAME_LEN 24
`define TRX_ADDR_BITS 7
`define TRX_DATA_BITS 16

`endif

// ---- src/trx_serial_port.v ----
// Three-wire serial frame receiver and read shifter, sampled on mclk
`timescale 1ns/1ps
`include "trx_regs_map.vh"
module trx_serial_port
(
	// Clock and reset
	input  wire        mclk,
	input  wire        rst,
	// Synchronised pins
	input  wire        sen_n_s,
	input  wire        sck_rise,
	input  wire        sck_fall,
	input  wire        sdi_s,
	// Register side
	output reg         wr_stb_q,
	output reg  [6:0]  addr_q,
	output reg  [15:0] wdata_q,
	input  wire [15:0] rdata,
	output reg         sdo_q,
	output reg         sdo_oe_q
);
	reg [4:0]  cnt_q;
	reg        rnw_q;
	reg [15:0] shf_q;

	always @(posedge mclk)
	begin
		wr_stb_q <= 1'b0;
		if (rst || sen_n_s)
		begin
			cnt_q    <= 5'h00;
			sdo_oe_q <= 1'b0;
			sdo_q    <= 1'b0;
		end
		else if (sck_rise)
		begin
			// Stop at the frame length so extra clocks change nothing
			if (cnt_q != 5'h18)
				cnt_q <= cnt_q + 5'h01;
			// MSB first: rw, address, data
			if (cnt_q == 5'h00)
				rnw_q <= sdi_s;
			else if (cnt_q <= 5'h07)
				addr_q <= {addr_q[5:0], sdi_s};
			else if (cnt_q < 5'h18)
			begin
				wdata_q <= {wdata_q[14:0], sdi_s};
				if (cnt_q == 5'h17 && !rnw_q)
					wr_stb_q <= 1'b1;
			end
		end
		else if (sck_fall && rnw_q && cnt_q >= 5'h08 && cnt_q < 5'h18)
		begin
			// Drive on falling edge so host samples on rising edge
			sdo_oe_q <= 1'b1;
			// Address is complete only after the eighth rise
			if (cnt_q == 5'h08)
			begin
				sdo_q <= rdata[15];
				shf_q <= {rdata[14:0], 1'b0};
			end
			else
			begin
				sdo_q <= shf_q[15];
				shf_q <= {shf_q[14:0], 1'b0};
			end
		end
	end
endmodule

// ---- test/trx_host_model.sv ----
// Host side of the serial control port, framing register accesses
`timescale 1ns/1ps
module trx_host_model
(
	// Clock
	input  wire        mclk,
	// Serial pins
	output logic       sen_n,
	output logic       sck,
	output logic       sdi,
	input  wire        sdo_q,
	input  wire        sdo_oe_q
);
	initial
	begin
		sen_n = 1'b1;
		sck = 1'b0;
		sdi = 1'b0;
	end

	// One whole frame; sck idles low between frames
	task automatic xfer(input bit rd, input logic [6:0] a,
		input logic [15:0] wd, output logic [15:0] rdat);
		logic [23:0] f;
		f = {rd, a, wd};
		rdat = 16'h0000;
		@(negedge mclk);
		sen_n = 1'b0;
		for (int i = 23; i >= 0; i--)
		begin
			sdi = f[i];
			repeat (4) @(negedge mclk);
			// An undriven line shows the inverse of its last value
			if (i < 16)
				rdat[i] = sdo_oe_q ? sdo_q : ~sdo_q;
			sck = 1'b1;
			repeat (4) @(negedge mclk);
			sck = 1'b0;
		end
		repeat (4) @(negedge mclk);
		sen_n = 1'b1;
		// Released data line must not look held
		sdi = ~sdi;
		repeat (8) @(negedge mclk);
	endtask
endmodule

// ---- test/trx_ctrl_regs_properties.sv ----
// Concurrent checks on the register bank ports
`timescale 1ns/1ps
module trx_ctrl_regs_properties
(
	// Clock and reset
	input wire        mclk,
	input wire        rst,
	// Pins and status
	input wire        sen_n,
	input wire        pdn_pin,
	input wire        code_sample,
	input wire        dtmf_ready,
	input wire        squelch_match,
	// Watched outputs
	input wire        sdo_oe_q,
	input wire        pin3_out_q,
	input wire        pin6_out_q,
	input wire        chip_enable_q,
	input wire        audio_mute_q,
	input wire        rx_on_q,
	input wire        tx_on_q,
	input wire        rf_out_en_q,
	input wire [15:0] irq_enable_q,
	input wire [29:0] rf_freq_q
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	// Four cycles covers the two-stage pin sync
	sequence s_pin_on;
		pdn_pin [*4];
	endsequence
	sequence s_frame_off;
		sen_n [*4];
	endsequence

	a_reset_clear: assert property (disable iff (1'b0)
		rst |=> !tx_on_q && !rf_out_en_q && !sdo_oe_q && rf_freq_q == 30'h0)
		else $error("outputs not cleared by reset");
	a_pin3_source: assert property (
		pin3_out_q |-> $past(code_sample) || $past(dtmf_ready))
		else $error("pin 3 high without a source");
	a_pin6_source: assert property (
		pin6_out_q |-> $past(squelch_match))
		else $error("pin 6 high without squelch");
	a_pin_enable: assert property (
		s_pin_on |=> chip_enable_q)
		else $error("chip not enabled by pin");
	a_mute_rx: assert property (
		audio_mute_q |-> rx_on_q)
		else $error("mute outside receive");
	a_rf_gate: assert property (
		rf_out_en_q |-> tx_on_q || rx_on_q || $past(tx_on_q) || $past(rx_on_q))
		else $error("rf output with radio off");
	a_irq_mask: assert property (
		(irq_enable_q & 16'hf43a) == 16'h0000)
		else $error("reserved irq enable set");
	a_oe_idle: assert property (
		s_frame_off |=> !sdo_oe_q)
		else $error("data out driven outside frame");
	a_oe_start: assert property (
		$rose(sdo_oe_q) |-> !sen_n && !$past(sen_n))
		else $error("data out driven without select");
endmodule

bind trx_ctrl_regs trx_ctrl_regs_properties i_props
(
	.mclk, .rst, .sen_n, .pdn_pin, .code_sample, .dtmf_ready,
	.squelch_match, .sdo_oe_q, .pin3_out_q, .pin6_out_q,
	.chip_enable_q, .audio_mute_q, .rx_on_q, .tx_on_q,
	.rf_out_en_q, .irq_enable_q, .rf_freq_q
);

// ---- test/trx_ctrl_regs_tb_top.sv ----
// Self-checking bench for the transceiver register bank
`timescale 1ns/1ps
module trx_ctrl_regs_tb_top;
	logic        mclk, rst, pdn_pin, sen_n, sck, sdi, sdo_q, sdo_oe_q;
	logic [7:0]  rf_strength_level, noise_level;
	logic [7:0]  tx_path_level, microphone_level;
	logic        tone_a_match, tone_b_match, code_normal_match;
	logic        code_inverted_match, phase_detect, subaudio_match;
	logic        vox_match, squelch_match, code_sample, dtmf_ready;
	logic        synth_locked, rf_out_en_q, xtal_26m_q, half_rate_ref_q;
	logic        wide_analog_q, wide_dsp_q, tx_on_q, rx_on_q;
	logic        audio_mute_q, vox_enable_q, auto_squelch_enable_q;
	logic        tail_elim_q, chip_enable_q, cal_enable_q;
	logic        tx_converter_reset_q, signal_proc_reset_q;
	logic        pin3_out_q, pin6_out_q;
	logic [1:0]  phase_shift;
	logic [2:0]  ldo_code_q;
	logic [5:0]  agc_target_q;
	logic [15:0] irq_enable_q, filter_bypass_q, w, c;
	logic [29:0] rf_freq_q;
	logic [31:0] seed = 32'h451d_8aeb;
	logic [15:0] m [128];
	int          miscompares = 0;
	int          samples_checked = 0;
	int          ib [7] = '{11, 9, 8, 7, 6, 2, 0};
	logic [6:0]  rw_a [17] = '{7'h03, 7'h04, 7'h08, 7'h09, 7'h0a, 7'h15,
		7'h24, 7'h29, 7'h2a, 7'h2d, 7'h30, 7'h32, 7'h3a, 7'h41, 7'h44,
		7'h4e, 7'h58};
	logic [15:0] rw_d [17] = '{16'h2b51, 16'h0fd1, 16'h02a0, 16'h03c2,
		16'h7c20, 16'h1100, 16'h0001, 16'h2486, 16'h3a84, 16'h0000,
		16'h0000, 16'h7497, 16'h40c3, 16'h4006, 16'h00ff, 16'h20c2,
		16'h8481};

	trx_host_model i_host
	(
		.mclk, .sen_n, .sck, .sdi, .sdo_q, .sdo_oe_q
	);

	trx_ctrl_regs i_dut
	(
		.mclk, .rst, .sen_n, .sck, .sdi, .sdo_q, .sdo_oe_q, .pdn_pin,
		.rf_strength_level, .noise_level, .tx_path_level,
		.microphone_level, .tone_a_match, .tone_b_match,
		.code_normal_match, .code_inverted_match, .phase_detect,
		.phase_shift, .subaudio_match, .vox_match, .squelch_match,
		.synth_locked, .code_sample, .dtmf_ready, .rf_out_en_q,
		.ldo_code_q, .xtal_26m_q, .half_rate_ref_q, .wide_analog_q,
		.wide_dsp_q, .tx_on_q, .rx_on_q, .audio_mute_q, .vox_enable_q,
		.auto_squelch_enable_q, .tail_elim_q, .chip_enable_q,
		.cal_enable_q, .tx_converter_reset_q, .signal_proc_reset_q,
		.rf_freq_q, .agc_target_q, .irq_enable_q, .filter_bypass_q,
		.pin3_out_q, .pin6_out_q
	);

	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [15:0] exp_rd(input logic [6:0] a);
		case (a)
		7'h00: return 16'h0a5a;
		7'h01: return 16'h0001;
		7'h0d: return {synth_locked, 15'h0000};
		7'h1a: return {tx_path_level, microphone_level};
		7'h1b: return {rf_strength_level, noise_level};
		7'h1c: return {6'h00, tone_a_match, tone_b_match, code_normal_match,
			code_inverted_match, phase_detect, phase_shift, subaudio_match,
			vox_match, squelch_match};
		7'h29: return m[a] & 16'h3fff;
		7'h2d: return m[a] & 16'h0bc5;
		default: return m[a];
		endcase
	endfunction

	task automatic load_defaults();
		for (int i = 0; i < 128; i++)
			m[i] = 16'h0000;
		for (int i = 0; i < 17; i++)
			m[rw_a[i]] = rw_d[i];
	endtask

	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		logic [15:0] x;
		i_host.xfer(1'b0, a, d, x);
		for (int i = 0; i < 17; i++)
			if (rw_a[i] == a)
				m[a] = d;
		if (a == 7'h30 && d[0])
			load_defaults();
	endtask

	task automatic chk_rd(input logic [6:0] a);
		logic [15:0] g, k;
		k = (a == 7'h0d) ? 16'h8000 : 16'hffff;
		i_host.xfer(1'b1, a, 16'h0000, g);
		samples_checked++;
		if ((g & k) !== (exp_rd(a) & k))
		begin
			miscompares++;
			$display("BAD %0t read %h got %h", $time, a, g);
		end
	endtask

	task automatic chk_out(input logic [31:0] g, e, input string n);
		samples_checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD %0t port %s got %h", $time, n, g);
		end
	endtask

	task automatic new_status();
		{rf_strength_level, noise_level, tx_path_level,
			microphone_level} = rnd();
		w = 16'(rnd());
		{tone_a_match, tone_b_match, code_normal_match, code_inverted_match,
			phase_detect, phase_shift, subaudio_match, vox_match,
			squelch_match} = w[9:0];
		{synth_locked, code_sample, dtmf_ready, pdn_pin} = w[13:10];
	endtask

	task automatic check_ports();
		c = m[7'h30];
		repeat (8) @(negedge mclk);
		chk_out(xtal_26m_q, c[14], "xtal");
		chk_out({wide_analog_q, wide_dsp_q}, c[13:12], "band");
		chk_out({tx_on_q, rx_on_q}, c[6:5], "txrx");
		chk_out(audio_mute_q, c[7] & c[5], "mute");
		chk_out({vox_enable_q, auto_squelch_enable_q, tail_elim_q},
			{c[4], c[3], c[11]}, "det");
		chk_out({chip_enable_q, cal_enable_q},
			{c[2] | pdn_pin, c[1]}, "pwr");
		chk_out(half_rate_ref_q, m[7'h04][0], "half");
		chk_out(ldo_code_q, m[7'h08][14] ? 3'h0 : m[7'h09][9:7], "ldo");
		chk_out({tx_converter_reset_q, signal_proc_reset_q},
			{&m[7'h03][12:11], &m[7'h24][7:6]}, "rst");
		chk_out(rf_out_en_q, (c[6] | c[5])
			& (synth_locked | m[7'h24][15]), "rf");
		chk_out(rf_freq_q, {m[7'h29][13:0], m[7'h2a]}, "freq");
		chk_out(agc_target_q, m[7'h32][11:6], "agc");
		chk_out(irq_enable_q, m[7'h2d] & 16'h0bc5, "irq");
		chk_out(filter_bypass_q, m[7'h58], "filt");
		chk_out(pin3_out_q, m[7'h3a][15] ? code_sample : dtmf_ready, "p3");
		chk_out(pin6_out_q, squelch_match
			& (subaudio_match | ~m[7'h3a][11]), "p6");
	endtask

	task automatic close_out();
		if (miscompares == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		rst = 1'b1;
		new_status();
		load_defaults();
		repeat (16) @(negedge mclk);
		rst = 1'b0;
		repeat (4) @(negedge mclk);
		for (int i = 0; i < 17; i++)
			chk_rd(rw_a[i]);
		check_ports();
		wr(7'h00, 16'h1234);
		wr(7'h01, 16'hffff);
		wr(7'h02, 16'h5555);
		chk_rd(7'h00);
		chk_rd(7'h01);
		chk_rd(7'h02);
		for (int n = 0; n < 12; n++)
		begin
			@(negedge mclk);
			new_status();
			for (int i = 0; i < 17; i++)
			begin
				w = 16'(rnd());
				if (rw_a[i] == 7'h30)
					w[0] = 1'b0;
				if (rw_a[i] == 7'h2d)
					w = 16'h0001 << ib[w[7:0] % 7];
				wr(rw_a[i], w);
			end
			chk_rd(7'h1a);
			chk_rd(7'h1b);
			chk_rd(7'h1c);
			chk_rd(7'h0d);
			chk_rd(7'h29);
			chk_rd(7'h2d);
			chk_rd(7'h58);
			chk_rd(7'h30);
			check_ports();
		end
		wr(7'h30, 16'h0001);
		for (int i = 0; i < 17; i++)
			chk_rd(rw_a[i]);
		check_ports();
		close_out();
	end

	// Run needs about 70000 cycles
	initial
	begin
		repeat (90000) @(posedge mclk);
		miscompares++;
		close_out();
	end
endmodule
